// >>> shared/dctcm_map.vh
// Timing and code constants for the dual channel torque cutoff monitor.
`ifndef DCTCM_MAP_VH
`define DCTCM_MAP_VH
`define DCTCM_CLK_HZ          100000000
`define DCTCM_TICK_MS         1
`define DCTCM_SKEW_MS         120
`define DCTCM_DIAG_DELAY_MS   630
`define DCTCM_DIAG_MIN_MS     190
`define DCTCM_DIAG_MAX_MS     1480
`define DCTCM_SHUTDOWN_MAX_MS 1600
`define DCTCM_INTERRUPT_MS    200
`define DCTCM_ERR_FAULT       10'h0215
`define DCTCM_ERR_INTERRUPT   10'h0213
`define DCTCM_ERR_DIAG        10'h03C0
`define DCTCM_ERR_NONE        10'h0000
`endif

// >>> rtl/dctcm_ms_tick.v
// Millisecond tick generator derived from the system clock.
`timescale 1ns/1ps
`include "dctcm_map.vh"
module dctcm_ms_tick #(
  parameter integer CYCLES_PER_MS = `DCTCM_CLK_HZ / 1000
) (
  input  wire sys_clk,
  input  wire reset_n,
  output reg  tick_ff
);
  reg [19:0] count_ff;
  wire       wrap = (count_ff == CYCLES_PER_MS - 1);

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= 20'h0_0000;
      tick_ff  <= 1'b0;
    end else begin
      count_ff <= wrap ? 20'h0_0000 : count_ff + 20'h0_0001;
      tick_ff  <= wrap;
    end
  end
endmodule // dctcm_ms_tick

// >>> rtl/dctcm_monitor.v
// Two channel safe torque off monitor with skew check and latched diagnosis.
`timescale 1ns/1ps
`include "dctcm_map.vh"
// Contract
// - Torque enabled only with both channels asserted.
// - Both channels low blocks all drive signals.
// - Either channel low alone disables output.
// - Compare channels continuously; shut down on mismatch.
// - Tolerate up to 120 ms channel skew.
// - Skew beyond tolerance raises error 533.
// - Persisting mismatch: error 960, 190-1480 ms later.
// - Diagnostic shutdown within 1600 ms of mismatch.
// - Diagnostic fault latches until power cycle.
// - Status output high while both active, enabled.
// - Re-enable automatically after channels reassert.
// - Channels dropped during travel: error 531 after 200 ms.
module dctcm_monitor #(
  parameter integer CYCLES_PER_MS = `DCTCM_CLK_HZ / 1000,
  parameter integer SKEW_MS       = `DCTCM_SKEW_MS,
  parameter integer DIAG_DELAY_MS = `DCTCM_DIAG_DELAY_MS,
  parameter integer INTERRUPT_MS  = `DCTCM_INTERRUPT_MS
) (
  input  wire       sys_clk,
  input  wire       reset_n,
  input  wire       power_on_n,
  input  wire       safe_off_channel_a,
  input  wire       safe_off_channel_b,
  input  wire       travel_active,
  input  wire       hw_defect,
  input  wire [5:0] gate_request,
  output reg  [5:0] gate_drive_ff,
  output reg        stage_enable_ff,
  output reg        torque_cutoff_status_out_ff,
  output reg        channel_fault_ff,
  output reg        interruption_fault_ff,
  output reg        diag_shutdown_ff,
  output reg  [9:0] error_code_ff
);
  localparam [2:0] ST_AGREE    = 3'b001;
  localparam [2:0] ST_SKEW     = 3'b010;
  localparam [2:0] ST_FAULTED  = 3'b100;

  // Two flip-flop synchronisers; the first stage feeds only the second.
  reg  [1:0] meta_ff;
  reg  [1:0] sync_ff;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= 2'h0;
      sync_ff <= 2'h0;
    end else begin
      meta_ff <= {safe_off_channel_b, safe_off_channel_a};
      sync_ff <= meta_ff;
    end
  end

  // The travel input comes from the lift controller's relays, so it is
  // synchronised like the channels.
  reg travel_meta_ff;
  reg travel_sync_ff;
  reg defect_meta_ff;
  reg defect_sync_ff;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      travel_meta_ff <= 1'b0;
      travel_sync_ff <= 1'b0;
      defect_meta_ff <= 1'b0;
      defect_sync_ff <= 1'b0;
    end else begin
      travel_meta_ff <= travel_active;
      travel_sync_ff <= travel_meta_ff;
      defect_meta_ff <= hw_defect;
      defect_sync_ff <= defect_meta_ff;
    end
  end

  wire ch_a      = sync_ff[0];
  wire ch_b      = sync_ff[1];
  wire both_on   = ch_a & ch_b;
  wire mismatch  = ch_a ^ ch_b;

  wire ms_tick;
  dctcm_ms_tick #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_tick (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .tick_ff (ms_tick)
  );

  // The diagnostic latch is cleared only by the power-on reset, not by the
  // ordinary system reset, so a power cycle is the one way out.
  reg        diag_latch_ff;
  reg [2:0]  state_ff;
  reg [2:0]  nxt_state;
  reg [10:0] skew_ms_ff;
  reg [10:0] nxt_skew_ms;
  reg [7:0]  drop_ms_ff;
  reg        was_travel_ff;

  always @* begin
    nxt_state   = state_ff;
    nxt_skew_ms = skew_ms_ff;
    case (state_ff)
      ST_AGREE: begin
        nxt_skew_ms = 11'h000;
        if (mismatch)
          nxt_state = ST_SKEW;
      end
      ST_SKEW: begin
        if (!mismatch) begin
          nxt_state   = ST_AGREE;
          nxt_skew_ms = 11'h000;
        end else if (ms_tick) begin
          nxt_skew_ms = skew_ms_ff + 11'h001;
        end
      end
      ST_FAULTED: begin
        // The latch holds this state while set. Once a power cycle has
        // cleared it, monitoring resumes so a later mismatch is caught.
        nxt_state   = ST_AGREE;
        nxt_skew_ms = 11'h000;
      end
      default: begin
        nxt_state   = ST_AGREE;
        nxt_skew_ms = 11'h000;
      end
    endcase
  end

  wire skew_over  = (state_ff == ST_SKEW) && mismatch &&
                    (skew_ms_ff >= SKEW_MS[10:0]);
  wire diag_trip  = skew_over &&
                    (skew_ms_ff >= SKEW_MS[10:0] + DIAG_DELAY_MS[10:0]);

  always @(posedge sys_clk or negedge power_on_n) begin
    if (!power_on_n)
      diag_latch_ff <= 1'b0;
    else if (diag_trip || defect_sync_ff)
      diag_latch_ff <= 1'b1;
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff   <= ST_AGREE;
      skew_ms_ff <= 11'h000;
    end else if (diag_latch_ff) begin
      state_ff   <= ST_FAULTED;
      skew_ms_ff <= skew_ms_ff;
    end else begin
      state_ff   <= nxt_state;
      skew_ms_ff <= nxt_skew_ms;
    end
  end

  // Interruption timer: channels dropped while a travel is under way.
  wire dropped = !ch_a && !ch_b;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      drop_ms_ff            <= 8'h00;
      was_travel_ff         <= 1'b0;
      interruption_fault_ff <= 1'b0;
    end else begin
      was_travel_ff <= travel_sync_ff;
      if (!(dropped && travel_sync_ff))
        drop_ms_ff <= 8'h00;
      else if (ms_tick && drop_ms_ff != 8'hFF)
        drop_ms_ff <= drop_ms_ff + 8'h01;
      if (dropped && travel_sync_ff &&
          drop_ms_ff >= INTERRUPT_MS[7:0])
        interruption_fault_ff <= 1'b1;
      else if (!travel_sync_ff && was_travel_ff)
        interruption_fault_ff <= 1'b0;
    end
  end

  // Enable re-arms by itself when both channels return; no acknowledge.
  wire enable_now = both_on && !diag_latch_ff;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_drive_ff               <= 6'h00;
      stage_enable_ff             <= 1'b0;
      torque_cutoff_status_out_ff <= 1'b0;
      channel_fault_ff            <= 1'b0;
      diag_shutdown_ff            <= 1'b0;
      error_code_ff               <= `DCTCM_ERR_NONE;
    end else begin
      stage_enable_ff  <= enable_now;
      gate_drive_ff    <= enable_now ? gate_request : 6'h00;
      torque_cutoff_status_out_ff <= enable_now;
      channel_fault_ff <= skew_over;
      diag_shutdown_ff <= diag_latch_ff;
      if (diag_latch_ff)
        error_code_ff <= `DCTCM_ERR_DIAG;
      else if (skew_over)
        error_code_ff <= `DCTCM_ERR_FAULT;
      else if (interruption_fault_ff)
        error_code_ff <= `DCTCM_ERR_INTERRUPT;
      else
        error_code_ff <= `DCTCM_ERR_NONE;
    end
  end
endmodule // dctcm_monitor

// >>> testbench/dctcm_lift_ctrl.sv
// Lift controller model switching the two safety relays.
`timescale 1ns/1ps
module dctcm_lift_ctrl (
  input  logic        sys_clk,
  input  logic        run,
  input  logic        solo_a,
  input  logic [15:0] lag,
  output logic        chan_a = 1'b0,
  output logic        chan_b = 1'b0
);
  logic [15:0] wait_ff = 16'h0000;
  // Relay B trails relay A by lag cycles, so skew can be dialled in.
  always @(posedge sys_clk) begin
    chan_a <= run | solo_a;
    if (chan_b == run) wait_ff <= 16'h0000;
    else if (wait_ff >= lag) chan_b <= run;
    else wait_ff <= wait_ff + 16'h0001;
  end
endmodule // dctcm_lift_ctrl

// >>> testbench/dctcm_monitor_assertions.sv
// Concurrent checks on the torque cutoff monitor ports.
`timescale 1ns/1ps
module dctcm_monitor_chk #(
  parameter integer CYCLES_PER_MS = 10,
  parameter integer SKEW_MS       = 120
) (
  input logic       sys_clk,
  input logic       reset_n,
  input logic       power_on_n,
  input logic       safe_off_channel_a,
  input logic       safe_off_channel_b,
  input logic [5:0] gate_drive_ff,
  input logic       stage_enable_ff,
  input logic       torque_cutoff_status_out_ff,
  input logic       channel_fault_ff,
  input logic       interruption_fault_ff,
  input logic       diag_shutdown_ff,
  input logic [9:0] error_code_ff
);
  localparam int C = CYCLES_PER_MS;
  int mis_ff;
  wire lo = !safe_off_channel_a || !safe_off_channel_b;
  always @(posedge sys_clk or negedge reset_n)
    if (!reset_n) mis_ff <= 0;
    else if (safe_off_channel_a != safe_off_channel_b) mis_ff <= mis_ff + 1;
    else mis_ff <= 0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_rise;
    $rose(stage_enable_ff) |-> $past(!lo, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("enable without channels");
  property p_off;
    lo [*4] |=> !stage_enable_ff;
  endproperty
  a_off: assert property (p_off) else $error("stage stayed on");
  property p_gate;
    (!safe_off_channel_a && !safe_off_channel_b) [*4] |=>
      gate_drive_ff == 6'h00;
  endproperty
  a_gate: assert property (p_gate) else $error("gates driven");
  property p_lock;
    diag_shutdown_ff [*2] |-> !stage_enable_ff && error_code_ff == 10'h3c0;
  endproperty
  a_lock: assert property (p_lock) else $error("diag state wrong");
  property p_hold;
    diag_shutdown_ff && power_on_n |=> diag_shutdown_ff || !power_on_n;
  endproperty
  a_hold: assert property (p_hold) else $error("diag released");
  property p_skew;
    $rose(channel_fault_ff) |-> mis_ff >= (SKEW_MS - 1) * C;
  endproperty
  a_skew: assert property (p_skew) else $error("fault too early");
  property p_late;
    mis_ff > (SKEW_MS + 2) * C |-> channel_fault_ff || diag_shutdown_ff;
  endproperty
  a_late: assert property (p_late) else $error("fault missing");
  property p_diag;
    mis_ff > 1600 * C |-> diag_shutdown_ff;
  endproperty
  a_diag: assert property (p_diag) else $error("diag too late");
  property p_status;
    torque_cutoff_status_out_ff == stage_enable_ff;
  endproperty
  a_status: assert property (p_status) else $error("status wrong");
  c_fault: cover property ($rose(channel_fault_ff));
  c_diag: cover property ($rose(diag_shutdown_ff));
  c_int: cover property ($rose(interruption_fault_ff));
endmodule // dctcm_monitor_chk
bind dctcm_monitor dctcm_monitor_chk #(.CYCLES_PER_MS(CYCLES_PER_MS),
  .SKEW_MS(SKEW_MS)) chk_u (.sys_clk, .reset_n, .power_on_n,
  .safe_off_channel_a, .safe_off_channel_b, .gate_drive_ff, .stage_enable_ff,
  .torque_cutoff_status_out_ff,
  .channel_fault_ff, .interruption_fault_ff, .diag_shutdown_ff, .error_code_ff);

// >>> testbench/dctcm_monitor_bench.sv
// Self-checking bench for the torque cutoff monitor.
`timescale 1ns/1ps
module dctcm_monitor_bench;
  logic sys_clk = 0, reset_n = 0, power_on_n = 0, run = 0, solo = 0;
  logic travel = 0, defect = 0, en, st, cf, itf, dg, a, b;
  logic [5:0] req = 6'h00, gd;
  logic [9:0] ec;
  logic [15:0] lag = 16'h0000;
  logic [20:0] q[$];
  int error_cnt = 0, cmp_count = 0;
  event look;
  dctcm_lift_ctrl ctl_u (.sys_clk, .run, .solo_a(solo), .lag, .chan_a(a),
    .chan_b(b));
  dctcm_monitor #(.CYCLES_PER_MS(10)) dut_u (.sys_clk, .reset_n, .power_on_n,
    .safe_off_channel_a(a), .safe_off_channel_b(b), .travel_active(travel),
    .hw_defect(defect), .gate_request(req), .gate_drive_ff(gd),
    .stage_enable_ff(en), .torque_cutoff_status_out_ff(st),
    .channel_fault_ff(cf), .interruption_fault_ff(itf),
    .diag_shutdown_ff(dg), .error_code_ff(ec));
  initial forever #5 sys_clk = ~sys_clk;
  task step(input int n); repeat (n) @(posedge sys_clk); #1; endtask
  task chk(input logic [20:0] e); q.push_back(e); ->look; endtask
  task tally_and_finish;
    $display("Compares %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(look) begin : watch
    logic [20:0] e;
    e = q.pop_front();
    cmp_count++;
    if ({gd, en, st, cf, itf, dg, ec} !== e) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time,
        {gd, en, st, cf, itf, dg, ec}, e);
    end
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h03c3_5aaf));
    step(16);
    reset_n = 1; power_on_n = 1; run = 1;
    repeat (3) begin
      req = $urandom;
      step(8); chk({req, 5'h18, 10'h000});
    end
    lag = 16'h01f4; run = 0;
    step(8); chk({6'h00, 5'h00, 10'h000});
    run = 1;
    step(8); chk({req, 5'h18, 10'h000});
    lag = 16'h0000; run = 0;
    step(8); chk({6'h00, 5'h00, 10'h000});
    lag = 16'h03e8; run = 1;
    step(1100); chk({req, 5'h18, 10'h000});
    lag = 16'h0000; travel = 1; step(4); run = 0;
    step(2050); chk({6'h00, 5'h02, 10'h213});
    travel = 0; solo = 1;
    step(1250); chk({6'h00, 5'h04, 10'h215});
    step(14800); chk({6'h00, 5'h01, 10'h3c0});
    solo = 0; run = 1;
    step(8); chk({6'h00, 5'h01, 10'h3c0});
    power_on_n = 0; step(2); power_on_n = 1;
    step(8); chk({req, 5'h18, 10'h000});
    defect = 1;
    step(8); chk({6'h00, 5'h01, 10'h3c0});
    tally_and_finish;
  end
endmodule // dctcm_monitor_bench
